//--- logic/instruction_format_load_decode.sv
// instruction decoder and load engine behind an ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - word is opcode, modifier, operand fields
// - shared opcodes split by other fields
// - modifier digit 7: type 2 or unmodified
// - operand taken from bits 9 to 23
// - three-bit codes select the working registers
// - byte control bits enable bytes 0-2
// - type 2 gives a six-bit count
// - type 1 operand is a memory address
// - loads use type 1, index and indirect
// - loads leave condition codes untouched
// - no load ever targets the program register
// - single load copies word into target
// - pair load reads address and address or 1
// - codes 1 and 2 load register pairs
// - codes 0 and 1 are read-only constants
// - program register holds address in bits 9-23
module instruction_format_load_decode #(
  parameter int MEM_AW = 10  // main memory words, log2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  decode_if dif ();  // fields of the latched instruction

  // bus data-phase state
  logic dp_wr_q;
  logic dp_rd_q;
  logic [12:0] dp_addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  logic [31:0] rdata_d;  // read mux result
  logic accept;  // address phase taken this edge
  logic [2:0] size_unused;  // only whole words are carried

  // engine state
  ifd_pkg::exec_state_e state_q;
  logic [23:0] instr_q;
  logic [14:0] eaddr_q;  // effective address
  logic done_q;  // sticky completion flag
  logic foreign_q;  // last word was not a load
  logic [3:0] cc_q;  // overflow, zero, minus, carry
  logic [23:0] wreg_q [8];  // working registers by code
  logic [23:0] mem_q [2**MEM_AW];  // main memory

  // load write port
  logic ld_we;
  logic [2:0] ld_code;
  logic [MEM_AW-1:0] ld_idx;
  logic [23:0] ld_data;
  logic [23:0] idx_val;  // selected index register
  logic start;
  logic finish;
  logic done_clr;

  instr_field_decoder u_dec (
    .d(dif.dec)
  );
  assign dif.instr = instr_q;

  // register-file hit, used by the read mux and the write path
  function automatic logic wreg_hit(input logic [12:0] a);
    wreg_hit = !a[ifd_pkg::MEM_SEL_BIT] && (a[12:5] == ifd_pkg::OFS_WREG[12:5]);
  endfunction

  // memory window hit, likewise shared
  function automatic logic mem_hit(input logic [12:0] a);
    // word index bits above the array depth must be clear; shift keeps any depth legal
    mem_hit = a[ifd_pkg::MEM_SEL_BIT] && ((a[11:2] >> MEM_AW) == 10'h000);
  endfunction

  // outputs come straight from flops
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign size_unused = hsize;

  // an address phase is taken only while the bus is ready
  assign accept = hsel && htrans[1] && hready;

  // latch the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= '0;
    end else if (hready) begin
      dp_wr_q <= accept && hwrite;
      dp_rd_q <= accept && !hwrite;
      if (accept) begin
        dp_addr_q <= haddr[12:0];
      end
    end else begin
      // read wait cycle: the read is served now
      dp_rd_q <= 1'b0;
    end
  end

  // reads take one wait state so they always see the last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= '0;
      hresp_q <= 1'b0;
    end else if (accept && !hwrite) begin
      hreadyout_q <= 1'b0;
    end else if (dp_rd_q) begin
      hrdata_q <= rdata_d;
      hreadyout_q <= 1'b1;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (mem_hit(dp_addr_q)) begin
      rdata_d[23:0] = mem_q[dp_addr_q[MEM_AW+1:2]];
    end else if (wreg_hit(dp_addr_q)) begin
      unique case (dp_addr_q[4:2])
        ifd_pkg::CODE_ZERO: rdata_d[23:0] = ifd_pkg::RST_WORD;
        ifd_pkg::CODE_ONE: rdata_d[23:0] = ifd_pkg::ONE_WORD;
        default: rdata_d[23:0] = wreg_q[dp_addr_q[4:2]];
      endcase
    end else begin
      unique case (dp_addr_q)
        ifd_pkg::OFS_INSTR: rdata_d[23:0] = instr_q;
        ifd_pkg::OFS_STATUS: begin
          rdata_d[ifd_pkg::ST_BUSY] = (state_q != ifd_pkg::EX_IDLE);
          rdata_d[ifd_pkg::ST_DONE] = done_q;
          rdata_d[ifd_pkg::ST_FOREIGN] = foreign_q;
        end
        ifd_pkg::OFS_DECODE: begin
          rdata_d[5:0] = dif.opcode;
          rdata_d[ifd_pkg::DC_MOD_LSB +: 3] = dif.modf;
          rdata_d[ifd_pkg::DC_TYPE2] = dif.type2;
          rdata_d[ifd_pkg::DC_LOAD] = dif.is_load;
          rdata_d[ifd_pkg::DC_PAIR] = dif.is_pair;
          rdata_d[ifd_pkg::DC_IND] = dif.indirect;
          rdata_d[ifd_pkg::DC_IDX_LSB +: 2] = dif.index_sel;
        end
        ifd_pkg::OFS_SUBF: begin
          rdata_d[2:0] = dif.src;
          rdata_d[ifd_pkg::SF_DST_LSB +: 3] = dif.dst;
          rdata_d[ifd_pkg::SF_BCTL_LSB +: 3] = dif.bctl;
          rdata_d[ifd_pkg::SF_COUNT_LSB +: 6] = dif.count;
        end
        ifd_pkg::OFS_EADDR: rdata_d[14:0] = eaddr_q;
        ifd_pkg::OFS_CC: rdata_d[3:0] = cc_q;
        ifd_pkg::OFS_MASK: rdata_d[23:0] = dif.bmask;
        default: rdata_d = '0;
      endcase
    end
  end

  // a new instruction starts only when the engine is idle;
  // a write while busy is dropped rather than queued
  assign start = dp_wr_q && (dp_addr_q == ifd_pkg::OFS_INSTR) &&
    (state_q == ifd_pkg::EX_IDLE);

  // instruction register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_q <= ifd_pkg::RST_WORD;
    end else if (start) begin
      instr_q <= hwdata[23:0];
    end
  end

  // index register picked by the modifier digit
  always_comb begin
    idx_val = ifd_pkg::RST_WORD;
    unique case (dif.index_sel)
      2'h1: idx_val = wreg_q[ifd_pkg::CODE_IDX1];
      2'h2: idx_val = wreg_q[ifd_pkg::CODE_IDX2];
      2'h3: idx_val = wreg_q[ifd_pkg::CODE_IDX3];
      default: idx_val = ifd_pkg::RST_WORD;
    endcase
  end

  // engine sequencing: one cycle per step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ifd_pkg::EX_IDLE;
    end else begin
      unique case (state_q)
        ifd_pkg::EX_IDLE: begin
          if (start) begin
            state_q <= ifd_pkg::EX_INDEX;
          end
        end
        ifd_pkg::EX_INDEX: begin
          // only loads are executed here; other words are just decoded
          if (!dif.is_load) begin
            state_q <= ifd_pkg::EX_IDLE;
          end else if (dif.indirect) begin
            state_q <= ifd_pkg::EX_INDIR;
          end else begin
            state_q <= ifd_pkg::EX_FIRST;
          end
        end
        ifd_pkg::EX_INDIR: begin
          state_q <= ifd_pkg::EX_FIRST;
        end
        ifd_pkg::EX_FIRST: begin
          if (dif.is_pair) begin
            state_q <= ifd_pkg::EX_SECOND;
          end else begin
            state_q <= ifd_pkg::EX_IDLE;
          end
        end
        ifd_pkg::EX_SECOND: begin
          state_q <= ifd_pkg::EX_IDLE;
        end
        default: begin
          state_q <= ifd_pkg::EX_IDLE;
        end
      endcase
    end
  end

  // effective address: operand plus index, then one level of indirection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eaddr_q <= '0;
    end else if (state_q == ifd_pkg::EX_INDEX) begin
      eaddr_q <= dif.operand + idx_val[14:0];
    end else if (state_q == ifd_pkg::EX_INDIR) begin
      // the pointer word carries its address in bits 9-23
      eaddr_q <= mem_q[eaddr_q[MEM_AW-1:0]][14:0];
    end
  end

  // memory port for the load: second word at the address or'd with 1,
  // so an odd address hands the same word to both registers
  always_comb begin
    ld_we = (state_q == ifd_pkg::EX_FIRST) || (state_q == ifd_pkg::EX_SECOND);
    ld_idx = eaddr_q[MEM_AW-1:0];
    ld_code = dif.first_code;
    if (state_q == ifd_pkg::EX_SECOND) begin
      ld_idx = eaddr_q[MEM_AW-1:0] | {{(MEM_AW-1){1'b0}}, 1'b1};
      ld_code = dif.second_code;
    end
    ld_data = mem_q[ld_idx];
  end

  // working registers; codes 0 and 1 keep their reset constants for good,
  // so one process owns each slot and nothing else drives the array
  for (genvar g = 0; g < 8; g++) begin : g_wreg
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wreg_q[g] <= (g == 1) ? ifd_pkg::ONE_WORD : ifd_pkg::RST_WORD;
      end else if (g > 2 && ld_we && ld_code == 3'(g)) begin
        // a load owns the cycle; a bus write to the same register loses
        wreg_q[g] <= ld_data;
      end else if (g > 1 && dp_wr_q && wreg_hit(dp_addr_q) && dp_addr_q[4:2] == 3'(g)) begin
        if (g == 2) begin
          // stands in for the branch and transfer paths outside this block
          wreg_q[g] <= hwdata[23:0] & ifd_pkg::PC_MASK;
        end else begin
          wreg_q[g] <= hwdata[23:0];
        end
      end
    end
  end

  // memory array: written from the bus only, no reset
  always_ff @(posedge hclk) begin
    if (dp_wr_q && mem_hit(dp_addr_q)) begin
      mem_q[dp_addr_q[MEM_AW+1:2]] <= hwdata[23:0];
    end
  end

  // condition codes: software only, loads never touch them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_q <= ifd_pkg::RST_CC;
    end else if (dp_wr_q && dp_addr_q == ifd_pkg::OFS_CC) begin
      cc_q <= hwdata[3:0];
    end
  end

  // last step of an instruction
  assign finish = (state_q == ifd_pkg::EX_SECOND) ||
    (state_q == ifd_pkg::EX_FIRST && !dif.is_pair) ||
    (state_q == ifd_pkg::EX_INDEX && !dif.is_load);
  assign done_clr = dp_wr_q && (dp_addr_q == ifd_pkg::OFS_STATUS) &&
    hwdata[ifd_pkg::ST_DONE];

  // done flag: write one to clear, a completion in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // records whether the last word was not a load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      foreign_q <= 1'b0;
    end else if (state_q == ifd_pkg::EX_INDEX) begin
      foreign_q <= !dif.is_load;
    end
  end
endmodule
`default_nettype wire

//--- logic/ifd_pkg.sv
// constants and types shared by the instruction decoder and its load engine
package ifd_pkg;
  // word and field widths
  localparam int WORD_W = 24;
  localparam int OPC_W = 6;
  localparam int MOD_W = 3;
  localparam int OPND_W = 15;
  localparam int CODE_W = 3;
  localparam int BCTL_W = 3;
  localparam int COUNT_W = 6;
  // field positions; doc bit k sits at vector index 23-k
  localparam int OPC_LSB = 18;
  localparam int MOD_LSB = 15;
  localparam int SRC_LSB = 12;
  localparam int DST_LSB = 9;
  localparam int BCTL_LSB = 5;
  localparam int COUNT_LSB = 0;
  // working register codes
  localparam logic [2:0] CODE_ZERO = 3'h0;
  localparam logic [2:0] CODE_ONE = 3'h1;
  localparam logic [2:0] CODE_PROG = 3'h2;
  localparam logic [2:0] CODE_ACC = 3'h3;
  localparam logic [2:0] CODE_EXT = 3'h4;
  localparam logic [2:0] CODE_IDX1 = 3'h5;
  localparam logic [2:0] CODE_IDX2 = 3'h6;
  localparam logic [2:0] CODE_IDX3 = 3'h7;
  // modification digit meanings
  localparam logic [2:0] MOD_NONE = 3'h7;
  localparam int MOD_IND_BIT = 2;
  localparam logic [2:0] LOAD_GROUP = 3'h0;
  // reset values
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [3:0] RST_CC = 4'h0;
  localparam logic [23:0] PC_MASK = 24'h007fff;
  localparam logic [23:0] ONE_WORD = 24'h000001;
  // register byte offsets
  localparam int ADEC_W = 13;
  localparam logic [12:0] OFS_INSTR = 13'h0000;
  localparam logic [12:0] OFS_STATUS = 13'h0004;
  localparam logic [12:0] OFS_DECODE = 13'h0008;
  localparam logic [12:0] OFS_SUBF = 13'h000c;
  localparam logic [12:0] OFS_EADDR = 13'h0010;
  localparam logic [12:0] OFS_CC = 13'h0014;
  localparam logic [12:0] OFS_MASK = 13'h0018;
  localparam logic [12:0] OFS_WREG = 13'h0020;
  localparam int MEM_SEL_BIT = 12;
  // status and decode field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FOREIGN = 2;
  localparam int DC_MOD_LSB = 8;
  localparam int DC_TYPE2 = 16;
  localparam int DC_LOAD = 17;
  localparam int DC_PAIR = 18;
  localparam int DC_IND = 19;
  localparam int DC_IDX_LSB = 20;
  localparam int SF_DST_LSB = 4;
  localparam int SF_BCTL_LSB = 8;
  localparam int SF_COUNT_LSB = 12;

  // load engine states
  typedef enum logic [2:0] {
    EX_IDLE = 3'b000,
    EX_INDEX = 3'b001,
    EX_INDIR = 3'b010,
    EX_FIRST = 3'b011,
    EX_SECOND = 3'b100
  } exec_state_e;

  // byte-control code to a word mask; msb of the code picks byte 0
  function automatic logic [23:0] byte_mask(input logic [2:0] bctl);
    byte_mask = {{8{bctl[2]}}, {8{bctl[1]}}, {8{bctl[0]}}};
  endfunction
endpackage

//--- logic/decode_if.sv
// instruction word and its decoded fields between engine and decoder
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
  logic [23:0] instr;
  logic [5:0] opcode;
  logic [2:0] modf;
  logic [14:0] operand;
  logic [2:0] src;
  logic [2:0] dst;
  logic [2:0] bctl;
  logic [23:0] bmask;
  logic [5:0] count;
  logic type2;
  logic [1:0] index_sel;
  logic indirect;
  logic is_load;
  logic is_pair;
  logic [2:0] first_code;
  logic [2:0] second_code;
  modport dec (input instr, output opcode, modf, operand, src, dst, bctl, bmask,
    count, type2, index_sel, indirect, is_load, is_pair, first_code, second_code);
  modport core (output instr, input opcode, modf, operand, src, dst, bctl, bmask,
    count, type2, index_sel, indirect, is_load, is_pair, first_code, second_code);
endinterface
`default_nettype wire

//--- logic/instr_field_decoder.sv
// combinational split of the instruction word into its fields
`timescale 1ns/100ps
`default_nettype none
module instr_field_decoder (
  decode_if.dec d
);
  logic [2:0] tgt;  // low opcode digit names the load target

  // three main fields, msb-first numbering
  assign d.opcode = d.instr[ifd_pkg::OPC_LSB +: ifd_pkg::OPC_W];
  assign d.modf = d.instr[ifd_pkg::MOD_LSB +: ifd_pkg::MOD_W];
  assign d.operand = d.instr[ifd_pkg::OPND_W-1:0];
  // type 2 subfields overlay the operand field
  assign d.src = d.instr[ifd_pkg::SRC_LSB +: ifd_pkg::CODE_W];
  assign d.dst = d.instr[ifd_pkg::DST_LSB +: ifd_pkg::CODE_W];
  assign d.bctl = d.instr[ifd_pkg::BCTL_LSB +: ifd_pkg::BCTL_W];
  assign d.bmask = ifd_pkg::byte_mask(d.bctl);
  assign d.count = d.instr[ifd_pkg::COUNT_LSB +: ifd_pkg::COUNT_W];
  // digit 7 means type 2 or no address modification
  // a load is always type 1, so there digit 7 only means unmodified
  assign d.type2 = (d.modf == ifd_pkg::MOD_NONE) && !d.is_load;
  assign d.index_sel = (d.modf == ifd_pkg::MOD_NONE) ? 2'h0 : d.modf[1:0];
  assign d.indirect = (d.modf != ifd_pkg::MOD_NONE) && d.modf[ifd_pkg::MOD_IND_BIT];
  // loads share one group; the low digit tells them apart
  assign tgt = d.opcode[2:0];
  assign d.is_load = (d.opcode[5:3] == ifd_pkg::LOAD_GROUP) &&
    (tgt != ifd_pkg::CODE_ZERO);
  assign d.is_pair = d.is_load &&
    (tgt == ifd_pkg::CODE_ONE || tgt == ifd_pkg::CODE_PROG);
  // code 2 is a pair load, so nothing ever lands in the program register
  always_comb begin
    d.first_code = tgt;
    d.second_code = tgt;
    if (tgt == ifd_pkg::CODE_ONE) begin
      d.first_code = ifd_pkg::CODE_ACC;
      d.second_code = ifd_pkg::CODE_IDX1;
    end else if (tgt == ifd_pkg::CODE_PROG) begin
      d.first_code = ifd_pkg::CODE_IDX2;
      d.second_code = ifd_pkg::CODE_IDX3;
    end
  end
endmodule
`default_nettype wire

//--- tb/ifd_asserts.sv
// bus-level and register-level checks bound to the decoder top
`timescale 1ns/100ps
`default_nettype none
module ifd_asserts #(
  parameter int MEM_AW = 10  // handed on from the top, memory depth log2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  logic rd_q;  // a read was taken at the previous edge
  logic [12:0] rd_addr_q;  // offset of the last read taken
  // remember reads so answers can be tied to their address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      rd_addr_q <= 13'h0000;
    end else begin
      rd_q <= hsel && htrans[1] && hready && !hwrite;
      if (hsel && htrans[1] && hready && !hwrite) begin
        rd_addr_q <= haddr[12:0];
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence write_taken;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  // a read answers after exactly one wait cycle
  sequence answer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_waits: assert property (read_taken |=> answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (write_taken |=> hreadyout)
    else $error("write inserted a wait");
  a_wait_has_cause: assert property ($fell(hreadyout) |-> rd_q)
    else $error("wait without a read");
  a_data_holds: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside an answer");
  a_top_byte_zero: assert property (hrdata[31:24] == 8'h00)
    else $error("read data above bit 23");
  a_zero_const: assert property ($rose(hreadyout) && rd_addr_q == 13'h0020 |->
    hrdata == 32'h00000000) else $error("zero constant register wrong");
  a_one_const: assert property ($rose(hreadyout) && rd_addr_q == 13'h0024 |->
    hrdata == 32'h00000001) else $error("one constant register wrong");
  a_prog_width: assert property ($rose(hreadyout) && rd_addr_q == 13'h0028 |->
    hrdata[23:15] == 9'h000) else $error("program register too wide");
endmodule
bind instruction_format_load_decode ifd_asserts #(.MEM_AW(MEM_AW)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp));
`default_nettype wire

//--- tb/ahb_master.sv
// ahb-lite master model standing where software reaches the block
`timescale 1ns/100ps
`default_nettype none
module ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // bus idle from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;  // whole words only
    hwdata = 32'h00000000;
  end
  // one single transfer; ready and read data are taken at the rising edge,
  // before the slave's flops update, so they are the values that edge samples
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h00000000;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the decoder and its load engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // bus wires
  logic [31:0] haddr, hwdata, hrdata, rd, st;  // rd: last answer, st: last status
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] bb;  // byte-control code under test
  int err_count, tests_run, n;
  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // single slave, so its ready is the bus ready
  instruction_format_load_decode #(.MEM_AW(10)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  ahb_master bfm (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    bfm.xfer(1'b1, {19'h0, a}, d, rd);
  endtask
  task automatic rchk(input string what, input logic [12:0] a, input logic [31:0] exp);
    bfm.xfer(1'b0, {19'h0, a}, 32'h0, rd);
    chk(what, exp, rd);
  endtask
  function automatic logic [12:0] wreg(input logic [2:0] c);
    return ifd_pkg::OFS_WREG + {8'h0, c, 2'b00};
  endfunction
  function automatic logic [12:0] mem(input int i);
    return 13'h1000 + 13'(i * 4);
  endfunction
  // load word: opcode high digit zero, low digit the target code
  function automatic logic [31:0] ld(input logic [2:0] c, input logic [2:0] m,
    input logic [14:0] a);
    return {8'h0, 3'h0, c, m, a};
  endfunction
  // poll until idle (bounded), check and clear the sticky done flag
  task automatic wait_idle();
    n = 0;
    do begin
      bfm.xfer(1'b0, {19'h0, ifd_pkg::OFS_STATUS}, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 40);
    chk("busy", 32'h0, {31'h0, st[0]});  // a poll limit that ran out counts here
    chk("done flag", 32'h1, {31'h0, st[1]});
    wr(ifd_pkg::OFS_STATUS, 32'h2);
  endtask
  task automatic run(input logic [31:0] w);
    wr(ifd_pkg::OFS_INSTR, w);
    wait_idle();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    err_count++;
    final_report();
  end
  initial begin
    hresetn = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("status", ifd_pkg::OFS_STATUS, 32'h0);
    rchk("instr", ifd_pkg::OFS_INSTR, 32'h0);
    rchk("cc", ifd_pkg::OFS_CC, 32'h0);
    // constants ignore writes; program register keeps only the address
    for (int c = 0; c < 3; c++) begin
      wr(wreg(3'(c)), 32'h00ffffff);
    end
    rchk("zero reg", wreg(3'h0), 32'h0);
    rchk("one reg", wreg(3'h1), 32'h1);
    rchk("prog reg", wreg(3'h2), 32'h00007fff);
    wr(13'h001c, 32'h00123456);
    rchk("unmapped", 13'h001c, 32'h0);
    $display("test registers done");
    // every single-word load target, with condition codes preset
    wr(ifd_pkg::OFS_CC, 32'h5);
    for (int c = 3; c < 8; c++) begin
      wr(mem(8 + c), 32'h00a50000 + 32'(c) * 32'h111);
      run(ld(3'(c), 3'h7, 15'(8 + c)));
      rchk("single load", wreg(3'(c)), 32'h00a50000 + 32'(c) * 32'h111);
    end
    rchk("decode", ifd_pkg::OFS_DECODE, 32'h00020707);
    rchk("cc kept", ifd_pkg::OFS_CC, 32'h5);
    $display("test single loads done");
    // pair loads, even then odd address
    wr(mem(20), 32'h00abcdef);
    wr(mem(21), 32'h00123456);
    run(ld(3'h1, 3'h7, 15'd20));
    rchk("pair acc", wreg(3'h3), 32'h00abcdef);
    rchk("pair idx1", wreg(3'h5), 32'h00123456);
    run(ld(3'h2, 3'h7, 15'd21));
    rchk("pair idx2", wreg(3'h6), 32'h00123456);
    rchk("pair idx3", wreg(3'h7), 32'h00123456);
    rchk("prog kept", wreg(3'h2), 32'h00007fff);
    rchk("decode pair", ifd_pkg::OFS_DECODE, 32'h00060702);
    $display("test pair loads done");
    // indexed, then indirect with a second start dropped while busy
    wr(wreg(3'h5), 32'h3);
    run(ld(3'h3, 3'h1, 15'd17));
    rchk("indexed addr", ifd_pkg::OFS_EADDR, 32'h14);
    rchk("indexed load", wreg(3'h3), 32'h00abcdef);
    wr(mem(30), 32'h14);
    wr(ifd_pkg::OFS_INSTR, ld(3'h4, 3'h4, 15'd30));
    wr(ifd_pkg::OFS_INSTR, ld(3'h3, 3'h7, 15'd8));
    wait_idle();
    rchk("instr kept", ifd_pkg::OFS_INSTR, ld(3'h4, 3'h4, 15'd30));
    rchk("indirect load", wreg(3'h4), 32'h00abcdef);
    rchk("acc untouched", wreg(3'h3), 32'h00abcdef);
    $display("test address modes done");
    // type 2 word through every byte-control code
    for (int b = 0; b < 8; b++) begin
      bb = 3'(b);
      run({8'h0, 6'o12, 3'h7, 3'h3, 3'h5, 1'b0, bb, 5'h13});
      rchk("byte mask", ifd_pkg::OFS_MASK, {8'h0, {8{bb[2]}}, {8{bb[1]}}, {8{bb[0]}}});
    end
    rchk("decode type2", ifd_pkg::OFS_DECODE, 32'h0001070a);
    rchk("subfields", ifd_pkg::OFS_SUBF, 32'h00033753);
    chk("not a load", 32'h1, {31'h0, st[2]});
    $display("test type 2 decode done");
    final_report();
  end
endmodule
`default_nettype wire
